// ===== design/cbr_card.sv
// Card side of the serial bus: commands, responses and block read data
`timescale 1ns/10ps
`default_nettype none
module cbr_card import cbr_pkg::*; #(
	parameter int ID_DLY = CBR_ID_DLY,
	parameter int CR_DLY = CBR_CR_DLY,
	parameter int AC_DLY = CBR_AC_DLY,
	parameter logic [31:0] OCR_VAL = 32'h80FF8000,
	parameter logic [127:0] CID_VAL = 128'h0,
	parameter logic [127:0] CSD_VAL = 128'h0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic bus_clk,
	input wire logic cmd_in,
	output logic cmd_out,
	output logic cmd_oe,
	output logic dat_out,
	output logic dat_oe,
	output var cbr_cmd_t host_cmd,
	output logic host_cmd_evt,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	output logic rd_ready
);
	cbr_cst_t cst_reg;
	cbr_card_t card_reg;
	cbr_card_t card_next;
	cbr_dst_t dst_reg;
	cbr_rsp_t rsp_kind;
	cbr_cmd_t rx_cmd;
	cbr_cmd_t cmd_x;
	logic [7:0] bit_cnt_reg;
	logic [46:0] rx_sh_reg;
	logic [7:0] wait_cnt_reg;
	logic [135:0] tx_sh_reg;
	logic [135:0] tx_load;
	logic [7:0] tx_cnt_reg;
	logic [7:0] tx_len_reg;
	logic tx_crc_on_reg;
	logic od_reg;
	logic z_reg;
	logic pull_reg;
	logic [15:0] rca_reg;
	logic [11:0] blk_reg;
	logic multi_reg;
	logic [15:0] acc_reg;
	logic [1:0] zc_reg;
	logic [15:0] dcnt_reg;
	logic [7:0] byte_sh_reg;
	logic stop_pend_reg;
	logic [3:0] st_code;
	logic [6:0] rx_crc;
	logic [6:0] tx_crc;
	logic [15:0] dat_crc;
	logic by_valid;
	logic [7:0] by_data;
	logic cmd_x_valid;
	logic [7:0] gap_cnt_reg;
	logic [15:0] dgap_reg;

	// Command frame decode; the pin is already in the bus clock domain
	wire logic [47:0] frame = {rx_sh_reg, cmd_in};
	wire logic [5:0] idx = frame[45:40];
	wire logic frame_end = (cst_reg == CS_RECV) && (bit_cnt_reg == 8'(CBR_CMD_BITS - 1));
	wire logic frame_ok = frame_end && frame[46] && frame[0] && (frame[7:1] == rx_crc);
	wire logic rca_hit = (frame[39:24] == rca_reg);
	wire logic is_rd = (idx == CBR_IDX_RD_ONE) || (idx == CBR_IDX_RD_MULTI);
	wire logic rd_go = frame_ok && is_rd && (card_reg == CARD_TRAN);
	wire logic stop_go = frame_ok && (idx == CBR_IDX_STOP) && (card_reg == CARD_DATA);
	wire logic od_sel = (idx == CBR_IDX_SEND_OP) || (idx == CBR_IDX_ALL_ID);
	wire logic pull_sel = !od_sel && (idx != CBR_IDX_SET_ADDR);
	wire logic [7:0] dly_sel = od_sel ? 8'(ID_DLY) : 8'(CR_DLY);
	wire logic [7:0] len_sel = (rsp_kind == RSP_CID || rsp_kind == RSP_CSD) ? 8'(CBR_R2_BITS) : 8'(CBR_CMD_BITS);
	assign rx_cmd = {idx, frame[39:8]};

	// Response bit: shift register, with the live check spliced into the check slot
	wire logic in_resp = (cst_reg == CS_RESP);
	wire logic resp_start = in_resp && (tx_cnt_reg == 8'h00);
	wire logic crc_slot = tx_crc_on_reg && (tx_cnt_reg >= 8'(CBR_CRC_POS)) && (tx_cnt_reg < 8'(CBR_CMD_BITS - 1));
	wire logic [7:0] crc_sel = 8'(CBR_CMD_BITS - 2) - tx_cnt_reg;
	wire logic tx_bit = crc_slot ? tx_crc[crc_sel[2:0]] : tx_sh_reg[135];
	wire logic pull_cyc = (cst_reg == CS_WAIT) && pull_reg && !z_reg;

	// Open-drain answers only ever pull low; released otherwise
	assign cmd_out = in_resp ? tx_bit : 1'b1;
	assign cmd_oe = in_resp ? (!od_reg || !tx_bit) : pull_cyc;

	// Response choice, next card state and status code
	always_comb begin
		rsp_kind = RSP_NONE;
		card_next = card_reg;
		case (idx)
			CBR_IDX_GO_IDLE: card_next = CARD_IDLE;
			CBR_IDX_SEND_OP: if (card_reg == CARD_IDLE || card_reg == CARD_READY) begin
				rsp_kind = RSP_R3;
				card_next = CARD_READY;
			end
			CBR_IDX_ALL_ID: if (card_reg == CARD_READY) begin
				rsp_kind = RSP_CID;
				card_next = CARD_IDENT;
			end
			CBR_IDX_SET_ADDR: if (card_reg == CARD_IDENT) begin
				rsp_kind = RSP_R1;
				card_next = CARD_STBY;
			end
			CBR_IDX_SELECT: if (card_reg == CARD_STBY && rca_hit) begin
				rsp_kind = RSP_R1;
				card_next = CARD_TRAN;
			end else if (card_reg == CARD_TRAN && !rca_hit) begin
				card_next = CARD_STBY;
			end
			CBR_IDX_SEND_CSD: if (card_reg == CARD_STBY && rca_hit) rsp_kind = RSP_CSD;
			CBR_IDX_SEND_CID: if (card_reg == CARD_STBY && rca_hit) rsp_kind = RSP_CID;
			CBR_IDX_STOP: if (card_reg == CARD_DATA) begin
				rsp_kind = RSP_R1;
				card_next = CARD_TRAN;
			end
			CBR_IDX_BLKLEN: if (card_reg == CARD_TRAN) rsp_kind = RSP_R1;
			CBR_IDX_RD_ONE, CBR_IDX_RD_MULTI: if (card_reg == CARD_TRAN) begin
				rsp_kind = RSP_R1;
				card_next = CARD_DATA;
			end
			default: rsp_kind = RSP_NONE;
		endcase
		case (card_reg)
			CARD_READY: st_code = 4'h1;
			CARD_IDENT: st_code = 4'h2;
			CARD_STBY: st_code = 4'h3;
			CARD_TRAN: st_code = 4'h4;
			CARD_DATA: st_code = 4'h5;
			default: st_code = 4'h0;
		endcase
	end

	// Frames left-aligned; register answers lose bit 0 to the end bit
	always_comb begin
		case (rsp_kind)
			RSP_R3: tx_load = {2'b00, CBR_RSV_IDX, OCR_VAL, CBR_RSV_CRC, 1'b1, 88'h0};
			RSP_CID: tx_load = {2'b00, CBR_RSV_IDX, CID_VAL[127:1], 1'b1};
			RSP_CSD: tx_load = {2'b00, CBR_RSV_IDX, CSD_VAL[127:1], 1'b1};
			default: tx_load = {2'b00, idx, 19'h0, st_code, 1'b1, 8'h00, 7'h00, 1'b1, 88'h0};
		endcase
	end

	cbr_crc u_rx_crc ( // Defaults give the seven-bit command check
		.clk(bus_clk),
		.rst(sys_rst),
		.clr(cst_reg == CS_IDLE),
		.en((cst_reg == CS_RECV) && (bit_cnt_reg < 8'(CBR_CRC_POS))),
		.bit_in(cmd_in),
		.crc_reg(rx_crc)
	);

	cbr_crc u_tx_crc ( // Same seven-bit check as the receive side
		.clk(bus_clk),
		.rst(sys_rst),
		.clr(cst_reg != CS_RESP),
		.en(in_resp && (tx_cnt_reg < 8'(CBR_CRC_POS))),
		.bit_in(tx_sh_reg[135]),
		.crc_reg(tx_crc)
	);

	// Command line sequencer; the card only listens while idle
	always_ff @(posedge bus_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cst_reg <= CS_IDLE;
			bit_cnt_reg <= 8'h00;
			rx_sh_reg <= '0;
			wait_cnt_reg <= 8'h00;
			tx_sh_reg <= '0;
			tx_cnt_reg <= 8'h00;
			tx_len_reg <= 8'h00;
			tx_crc_on_reg <= 1'b0;
			od_reg <= 1'b0;
			z_reg <= 1'b0;
			pull_reg <= 1'b0;
		end else begin
			case (cst_reg)
				CS_IDLE: if (!cmd_in) begin
					cst_reg <= CS_RECV;
					bit_cnt_reg <= 8'h01;
					rx_sh_reg <= '0;
				end
				CS_RECV: begin
					rx_sh_reg <= frame[46:0];
					bit_cnt_reg <= bit_cnt_reg + 8'h01;
					if (bit_cnt_reg == 8'h01 && !cmd_in)
						cst_reg <= CS_IDLE;
					else if (frame_end) begin
						cst_reg <= (frame_ok && rsp_kind != RSP_NONE) ? CS_WAIT : CS_IDLE;
						wait_cnt_reg <= dly_sel;
						z_reg <= 1'b1;
						pull_reg <= pull_sel;
						od_reg <= od_sel;
						tx_sh_reg <= tx_load;
						tx_len_reg <= len_sel;
						tx_crc_on_reg <= (rsp_kind == RSP_R1);
						tx_cnt_reg <= 8'h00;
					end
				end
				CS_WAIT: begin
					z_reg <= 1'b0;
					wait_cnt_reg <= wait_cnt_reg - 8'h01;
					if (wait_cnt_reg <= 8'h01)
						cst_reg <= CS_RESP;
				end
				CS_RESP: begin
					tx_sh_reg <= {tx_sh_reg[134:0], 1'b0};
					tx_cnt_reg <= tx_cnt_reg + 8'h01;
					if (tx_cnt_reg == tx_len_reg - 8'h01)
						cst_reg <= CS_IDLE;
				end
				default: cst_reg <= CS_IDLE;
			endcase
		end
	end

	// Data block geometry: start, 8 bits a byte, 16 check bits, end
	wire logic [15:0] dat_bits = {1'b0, blk_reg, 3'b000};
	wire logic [15:0] dat_last = dat_bits + 16'(CBR_DAT_CRC_BITS + 1);
	wire logic [15:0] crc_pos = dat_last - 16'h0001 - dcnt_reg;
	wire logic in_send = (dst_reg == DS_SEND);
	wire logic in_dbits = (dcnt_reg != 16'h0000) && (dcnt_reg <= dat_bits);
	wire logic blk_done = in_send && (dcnt_reg == dat_last) && !stop_pend_reg;
	wire logic first_go = (dst_reg == DS_WAIT) && (acc_reg <= 16'h0001) && by_valid && !stop_pend_reg;
	wire logic next_take = in_send && in_dbits && (dcnt_reg[2:0] == 3'h0) && (dcnt_reg < dat_bits);
	wire logic byte_take = first_go || next_take;
	wire logic dat_bit = (dcnt_reg == 16'h0000) ? 1'b0 : in_dbits ? byte_sh_reg[7] :
		(dcnt_reg == dat_last) ? 1'b1 : dat_crc[crc_pos[3:0]];

	// Truncated block ends on a 1 so the host sees a clean release
	assign dat_out = (stop_pend_reg || !in_send) ? 1'b1 : dat_bit;
	assign dat_oe = in_send || ((dst_reg == DS_WAIT) && (zc_reg == 2'h0));

	cbr_crc #(.W(16), .POLY(CBR_CRC16_POLY)) u_dat_crc (
		.clk(bus_clk),
		.rst(sys_rst),
		.clr(!in_send),
		.en(in_send && in_dbits),
		.bit_in(byte_sh_reg[7]),
		.crc_reg(dat_crc)
	);

	// Data line sequencer; a stop overrides everything one cycle later
	always_ff @(posedge bus_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dst_reg <= DS_IDLE;
			acc_reg <= 16'h0000;
			zc_reg <= 2'h0;
			dcnt_reg <= 16'h0000;
			byte_sh_reg <= 8'h00;
			stop_pend_reg <= 1'b0;
		end else if (stop_pend_reg) begin
			dst_reg <= DS_IDLE;
			stop_pend_reg <= 1'b0;
		end else begin
			stop_pend_reg <= stop_go;
			case (dst_reg)
				DS_IDLE: if (rd_go) begin
					dst_reg <= DS_WAIT;
					acc_reg <= 16'(AC_DLY);
					zc_reg <= 2'(CBR_DAT_Z_CYCLES);
				end
				DS_WAIT: begin
					if (zc_reg != 2'h0)
						zc_reg <= zc_reg - 2'h1;
					if (acc_reg > 16'h0001)
						acc_reg <= acc_reg - 16'h0001;
					if (first_go) begin
						dst_reg <= DS_SEND;
						dcnt_reg <= 16'h0000;
						byte_sh_reg <= by_data;
					end
				end
				DS_SEND: begin
					dcnt_reg <= dcnt_reg + 16'h0001;
					if (next_take)
						byte_sh_reg <= by_data; // Underrun repeats the stale byte
					else if (in_dbits)
						byte_sh_reg <= {byte_sh_reg[6:0], 1'b0};
					if (blk_done) begin
						dst_reg <= multi_reg ? DS_WAIT : DS_IDLE;
						acc_reg <= 16'(AC_DLY);
						zc_reg <= 2'h0;
					end
				end
				default: dst_reg <= DS_IDLE;
			endcase
		end
	end

	// Card state, relative address, block length and read mode
	always_ff @(posedge bus_clk or posedge sys_rst) begin
		if (sys_rst) begin
			card_reg <= CARD_IDLE;
			rca_reg <= 16'h0000;
			blk_reg <= CBR_BLK_RESET;
			multi_reg <= 1'b0;
		end else if (frame_ok) begin
			card_reg <= card_next;
			if (idx == CBR_IDX_SET_ADDR && card_reg == CARD_IDENT)
				rca_reg <= frame[39:24];
			if (idx == CBR_IDX_BLKLEN && card_reg == CARD_TRAN)
				blk_reg <= frame[19:8];
			if (rd_go)
				multi_reg <= (idx == CBR_IDX_RD_MULTI);
		end else if (blk_done && !multi_reg) begin
			card_reg <= CARD_TRAN;
		end
	end

	// Commands cross to the system clock for the storage side to act on
	cbr_xfer #(.W(38)) u_cmd_x (
		.src_clk(bus_clk),
		.dst_clk(clk),
		.rst(sys_rst),
		.src_valid(frame_ok),
		.src_data(rx_cmd),
		.src_ready(),
		.dst_valid(cmd_x_valid),
		.dst_data(cmd_x),
		.dst_ready(!host_cmd_evt) // A word waits while the last report is still shown
	);

	// Read bytes cross to the bus clock; the source stalls until the take
	cbr_xfer u_rd_x ( // Default width is one byte
		.src_clk(clk),
		.dst_clk(bus_clk),
		.rst(sys_rst),
		.src_valid(rd_valid),
		.src_data(rd_data),
		.src_ready(rd_ready),
		.dst_valid(by_valid),
		.dst_data(by_data),
		.dst_ready(byte_take)
	);

	// Registered command report on the system clock
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			host_cmd <= '0;
			host_cmd_evt <= 1'b0;
		end else begin
			host_cmd_evt <= cmd_x_valid;
			if (cmd_x_valid)
				host_cmd <= cmd_x;
		end
	end

	// Cycle counters watched only by the checks below
	always_ff @(posedge bus_clk or posedge sys_rst) begin
		if (sys_rst) begin
			gap_cnt_reg <= 8'h00;
			dgap_reg <= 16'h0000;
		end else begin
			gap_cnt_reg <= frame_end ? 8'h00 : gap_cnt_reg + {7'h00, gap_cnt_reg != 8'hFF};
			dgap_reg <= (rd_go || blk_done) ? 16'h0000 : dgap_reg + {15'h0000, dgap_reg != 16'hFFFF};
		end
	end

	default clocking cb @(posedge bus_clk); endclocking
	default disable iff (sys_rst);

	dir_bit_a: assert property (in_resp && tx_cnt_reg == 8'h01 |-> !cmd_out) else $error("direction bit not 0");
	r1_len_a: assert property (resp_start && tx_crc_on_reg |-> ##47 (cmd_out && in_resp) ##1 (cst_reg == CS_IDLE))
		else $error("checked response length wrong");
	od_drive_a: assert property (in_resp && od_reg && cmd_oe |-> !cmd_out) else $error("open-drain drove high");
	id_gap_a: assert property (resp_start && od_reg |-> gap_cnt_reg == 8'(ID_DLY)) else $error("ident delay wrong");
	cr_gap_a: assert property (resp_start && !od_reg |-> gap_cnt_reg >= 8'(CR_DLY)) else $error("response too early");
	turn_z_a: assert property (frame_ok && rsp_kind != RSP_NONE && pull_sel |=> !cmd_oe ##1 (cmd_oe && cmd_out))
		else $error("turnaround or pull-up missing");
	end_bit_a: assert property (in_resp && tx_cnt_reg == tx_len_reg - 8'h01 |-> cmd_out ##1 !cmd_oe)
		else $error("response end bit wrong");
	r2_len_a: assert property (resp_start && tx_len_reg == 8'(CBR_R2_BITS) |-> ##135 cmd_out ##1 !in_resp)
		else $error("register response length wrong");
	acc_gap_a: assert property (in_send && dcnt_reg == 16'h0000 |-> dgap_reg >= 16'(AC_DLY))
		else $error("read data too early");
	stop_rel_a: assert property (stop_go |-> ##2 !dat_oe) else $error("data not released after stop");
	dat_frame_a: assert property (in_send && dcnt_reg == 16'h0000 |-> dat_oe && !dat_out ##1 dat_oe)
		else $error("data start bit wrong");
	dat_end_a: assert property (blk_done && multi_reg |-> dat_out ##1 (dat_oe && dat_out && dst_reg == DS_WAIT))
		else $error("no pull-up between blocks");

	id_resp_c: cover property (resp_start && od_reg);
	r2_resp_c: cover property (resp_start && tx_len_reg == 8'(CBR_R2_BITS) && !od_reg);
	one_blk_c: cover property (blk_done && !multi_reg);
	multi_stop_c: cover property (blk_done && multi_reg ##[1:1000] stop_go);
endmodule : cbr_card
`default_nettype wire

// ===== inc/cbr_pkg.sv
// Shared constants and types of the card bus command and read engine
package cbr_pkg;
	localparam int CBR_CMD_BITS = 48;
	localparam int CBR_R2_BITS = 136;
	localparam int CBR_CRC_POS = 40;
	localparam int CBR_DAT_CRC_BITS = 16;
	localparam int CBR_DAT_Z_CYCLES = 2;
	localparam int CBR_ID_DLY = 5;
	localparam int CBR_CR_DLY = 2;
	localparam int CBR_AC_DLY = 16;
	localparam logic [11:0] CBR_BLK_RESET = 12'h200;
	localparam logic [6:0] CBR_CRC7_POLY = 7'h09;
	localparam logic [15:0] CBR_CRC16_POLY = 16'h1021;
	localparam logic [5:0] CBR_IDX_GO_IDLE = 6'h00;
	localparam logic [5:0] CBR_IDX_SEND_OP = 6'h01;
	localparam logic [5:0] CBR_IDX_ALL_ID = 6'h02;
	localparam logic [5:0] CBR_IDX_SET_ADDR = 6'h03;
	localparam logic [5:0] CBR_IDX_SELECT = 6'h07;
	localparam logic [5:0] CBR_IDX_SEND_CSD = 6'h09;
	localparam logic [5:0] CBR_IDX_SEND_CID = 6'h0A;
	localparam logic [5:0] CBR_IDX_STOP = 6'h0C;
	localparam logic [5:0] CBR_IDX_BLKLEN = 6'h10;
	localparam logic [5:0] CBR_IDX_RD_ONE = 6'h11;
	localparam logic [5:0] CBR_IDX_RD_MULTI = 6'h12;
	localparam logic [5:0] CBR_RSV_IDX = 6'h3F;
	localparam logic [6:0] CBR_RSV_CRC = 7'h7F;
	// Command as reported to the system side
	typedef struct packed {
		logic [5:0] index;
		logic [31:0] arg;
	} cbr_cmd_t;
	typedef enum logic [5:0] {
		CARD_IDLE = 6'h01, CARD_READY = 6'h02, CARD_IDENT = 6'h04,
		CARD_STBY = 6'h08, CARD_TRAN = 6'h10, CARD_DATA = 6'h20
	} cbr_card_t;
	typedef enum logic [3:0] {
		CS_IDLE = 4'h1, CS_RECV = 4'h2, CS_WAIT = 4'h4, CS_RESP = 4'h8
	} cbr_cst_t;
	typedef enum logic [2:0] {
		DS_IDLE = 3'h1, DS_WAIT = 3'h2, DS_SEND = 3'h4
	} cbr_dst_t;
	typedef enum logic [2:0] {
		RSP_NONE = 3'h0, RSP_R1 = 3'h1, RSP_R3 = 3'h2, RSP_CID = 3'h3, RSP_CSD = 3'h4
	} cbr_rsp_t;
endpackage : cbr_pkg

// ===== design/cbr_crc.sv
// Serial cyclic redundancy check register, one bit per clock
`timescale 1ns/10ps
`default_nettype none
module cbr_crc #(
	parameter int W = 7,
	parameter logic [W-1:0] POLY = 'h9
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic en,
	input wire logic bit_in,
	output logic [W-1:0] crc_reg
);
	// Feedback from the top bit, polynomial folded in when it is set
	wire logic fb = crc_reg[W-1] ^ bit_in;
	wire logic [W-1:0] crc_next = {crc_reg[W-2:0], 1'b0} ^ (fb ? POLY : '0);

	// Clear wins over a step, so a new frame never inherits the old check
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			crc_reg <= '0;
		else if (clr)
			crc_reg <= '0;
		else if (en)
			crc_reg <= crc_next;
	end
endmodule : cbr_crc
`default_nettype wire

// ===== design/cbr_xfer.sv
// Toggle handshake that carries one word between two clock domains
`timescale 1ns/10ps
`default_nettype none
module cbr_xfer #(
	parameter int W = 8
) (
	input wire logic src_clk,
	input wire logic dst_clk,
	input wire logic rst,
	input wire logic src_valid,
	input wire logic [W-1:0] src_data,
	output logic src_ready,
	output logic dst_valid,
	output logic [W-1:0] dst_data,
	input wire logic dst_ready
);
	logic req_reg;
	logic ack_reg;
	logic ack_s1_reg;
	logic ack_s2_reg;
	logic req_s1_reg;
	logic req_s2_reg;
	logic [W-1:0] hold_reg;

	// Word is held still until the far side has acknowledged it
	assign src_ready = (req_reg == ack_s2_reg);
	assign dst_valid = (req_s2_reg != ack_reg);
	assign dst_data = hold_reg;

	// Source side: capture and toggle the request
	always_ff @(posedge src_clk or posedge rst) begin
		if (rst) begin
			req_reg <= 1'b0;
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
			hold_reg <= '0;
		end else begin
			ack_s1_reg <= ack_reg;
			ack_s2_reg <= ack_s1_reg;
			if (src_valid && src_ready) begin
				hold_reg <= src_data;
				req_reg <= ~req_reg;
			end
		end
	end

	// Destination side: synchronise the request, echo it as acknowledge
	always_ff @(posedge dst_clk or posedge rst) begin
		if (rst) begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			ack_reg <= 1'b0;
		end else begin
			req_s1_reg <= req_reg;
			req_s2_reg <= req_s1_reg;
			if (dst_valid && dst_ready)
				ack_reg <= req_s2_reg;
		end
	end
endmodule : cbr_xfer
`default_nettype wire

// ===== sim/cbr_host_model.sv
// Host side of the card bus: link clock, command frames, response capture
`timescale 1ns/10ps
`default_nettype none
module cbr_host_model (
	output logic bus_clk,
	output logic host_oe,
	output logic host_out,
	input wire logic cmd_w,
	input wire logic card_oe
);
	logic cs;
	logic [7:0] oh;
	// Clock rests high between transfers, so a stall is a stopped clock
	initial begin
		bus_clk = 1'h1;
		host_oe = 1'h0;
		host_out = 1'h1;
		oh = 8'h00;
	end
	// One bus cycle; sample at the fall, where the card's outputs have settled
	task automatic cyc();
		bus_clk = 1'h0;
		cs = cmd_w;
		oh = {oh[6:0], card_oe};
		#32 bus_clk = 1'h1;
		#32;
	endtask : cyc
	function automatic logic [6:0] crc7(input logic [39:0] d);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 39; i >= 0; i--)
			c = {c[5:0], 1'h0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
		return c;
	endfunction : crc7
	// Command frame; bad flips one check bit to provoke a refusal
	task automatic send(input logic [5:0] idx, input logic [31:0] arg, input logic bad);
		logic [47:0] f;
		f = {2'h1, idx, arg, crc7({2'h1, idx, arg}) ^ {6'h00, bad}, 1'h1};
		host_oe = 1'h1;
		for (int i = 47; i >= 0; i--) begin
			host_out = f[i];
			cyc();
		end
		host_oe = 1'h0;
		host_out = 1'h1;
	endtask : send
	// Bounded wait for a start bit, the first of len bits; dly of 64 means silence
	task automatic recv(input int len, output int dly, output logic [7:0] wh, output logic [135:0] r);
		r = '0;
		dly = 0;
		do begin
			cyc();
			dly++;
		end while (cs !== 1'h0 && dly < 64);
		wh = oh;
		r[0] = cs;
		for (int i = 1; i < len && dly < 64; i++) begin
			cyc();
			r = {r[134:0], cs};
		end
	endtask : recv
	task automatic tick(input int n);
		repeat (n) cyc();
	endtask : tick
endmodule : cbr_host_model
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench of the card engine against the host model
`timescale 1ns/10ps
`default_nettype none
module tb_top import cbr_pkg::*;;
	localparam logic [127:0] CID = 128'h0123456789ABCDEF0F1E2D3C4B5A6978;
	localparam logic [31:0] OCR = 32'h00FF8000;
	localparam logic [15:0] RCA = 16'h0005;
	localparam logic [31:0] NB = 32'h4; // Short blocks keep the run brief
	logic clk, sys_rst, bus_clk, host_oe, host_out, cmd_out, cmd_oe, dat_out, dat_oe;
	logic rd_valid, rd_ready, took, od, host_cmd_evt;
	logic [7:0] rd_data;
	logic [15:0] doh;
	logic [48:0] sh;
	logic [135:0] resp;
	cbr_cmd_t host_cmd;
	wire logic cmd_w = host_oe ? host_out : (cmd_oe ? cmd_out : 1'h1);
	wire logic dat_w = dat_oe ? dat_out : 1'h1;
	int n_fail = 0, n_compared = 0, bc = 0, dn = 0, n_evt = 0;
	typedef struct {int st; logic [15:0] oh; logic [31:0] d; logic [15:0] c; logic e;} cbr_blk_t;
	cbr_blk_t blk[$], cur;
	cbr_host_model h (.bus_clk(bus_clk), .host_oe(host_oe), .host_out(host_out), .cmd_w(cmd_w), .card_oe(cmd_oe));
	cbr_card #(.OCR_VAL(OCR), .CID_VAL(CID)) dut (.clk(clk), .sys_rst(sys_rst), .bus_clk(bus_clk), .cmd_in(cmd_w),
		.cmd_out(cmd_out), .cmd_oe(cmd_oe), .dat_out(dat_out), .dat_oe(dat_oe), .host_cmd(host_cmd),
		.host_cmd_evt(host_cmd_evt), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// Byte source offers a running count; the card paces it with rd_ready
	always @(posedge clk) took <= rd_valid && rd_ready;
	always @(negedge clk) if (took) rd_data <= rd_data + 8'h01;
	// Every good command must be reported to the system side exactly once
	always @(posedge clk) if (host_cmd_evt === 1'h1) n_evt++;
	// Data line capture at the falling link edge, where all levels have settled
	always @(negedge bus_clk) begin
		bc++;
		if (od && cmd_oe === 1'h1) chk(cmd_out, 1'h0);
		if (dn > 0) begin
			sh = {sh[47:0], dat_w};
			dn++;
		end else if (dat_w === 1'h0) begin
			cur.st = bc;
			cur.oh = doh;
			dn = 1;
		end
		if (dn == 50) begin
			cur.d = sh[48:17];
			cur.c = sh[16:1];
			cur.e = sh[0];
			blk.push_back(cur);
			dn = 0;
		end
		doh = {doh[14:0], dat_oe};
	end
	task automatic chk(input logic [135:0] got, input logic [135:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [15:0] crc16(input logic [31:0] d);
		logic [15:0] c;
		c = 16'h0000;
		for (int i = 31; i >= 0; i--)
			c = {c[14:0], 1'h0} ^ ((d[i] ^ c[15]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction : crc16
	// Response framing, delay and which wait cycles the card drove
	task automatic rsp(input logic [5:0] idx, input int len, input int ed, input logic [7:0] ewh);
		int d;
		logic [7:0] wh;
		h.recv(len, d, wh, resp);
		chk(d, ed);
		chk(wh & (8'hFF >> (8 - ed)), ewh);
		chk({resp[len - 1 -: 2], resp[0]}, 3'h1);
		if (len == 48 && idx != 6'h3F) begin
			chk(resp[45:40], idx);
			chk(resp[7:1], h.crc7(resp[47:8]));
		end
	endtask : rsp
	task automatic chk_blk(input int i, input int t0, input logic [15:0] eoh);
		if (t0 > 0) chk(blk[i].st - t0, CBR_AC_DLY + 1);
		chk(blk[i].oh, eoh);
		chk(blk[i].c, crc16(blk[i].d));
		chk(blk[i].e, 1'h1);
		for (int k = 0; k < 3; k++) chk(blk[i].d[23 - 8 * k -: 8], blk[i].d[31 - 8 * k -: 8] + 8'h01);
	endtask : chk_blk
	// Open-drain identification, then address assignment with an all-released wait
	task automatic ident_phase();
		od = 1'h1;
		h.send(CBR_IDX_SEND_OP, OCR, 1'h0);
		rsp(6'h3F, 48, CBR_ID_DLY + 1, 8'h01);
		chk(resp[47:0], {8'h3F, OCR, 8'hFF});
		h.tick(8);
		h.send(CBR_IDX_ALL_ID, 32'h0, 1'h0);
		rsp(6'h3F, 136, CBR_ID_DLY + 1, 8'h01);
		chk(resp, {8'h3F, CID[127:1], 1'h1});
		od = 1'h0;
		h.tick(8);
		h.send(CBR_IDX_SET_ADDR, {RCA, 16'h0000}, 1'h0);
		rsp(CBR_IDX_SET_ADDR, 48, CBR_CR_DLY + 1, 8'h01);
		h.tick(8);
		h.send(CBR_IDX_SEND_CID, {RCA, 16'h0000}, 1'h0);
		rsp(6'h3F, 136, CBR_CR_DLY + 1, 8'h03);
		chk(resp, {8'h3F, CID[127:1], 1'h1});
		h.tick(8);
	endtask : ident_phase
	// Selection and block length, each answered after one released then one pulled-up cycle
	task automatic select_setup();
		h.send(CBR_IDX_SELECT, {RCA, 16'h0000}, 1'h0);
		rsp(CBR_IDX_SELECT, 48, CBR_CR_DLY + 1, 8'h03);
		h.tick(8);
		h.send(CBR_IDX_BLKLEN, NB, 1'h0);
		rsp(CBR_IDX_BLKLEN, 48, CBR_CR_DLY + 1, 8'h03);
		chk(host_cmd, {CBR_IDX_BLKLEN, NB});
		chk(n_evt, 6);
		h.tick(8);
	endtask : select_setup
	task automatic single_read();
		int t0;
		h.send(CBR_IDX_RD_ONE, 32'h00000200, 1'h0);
		t0 = bc;
		rsp(CBR_IDX_RD_ONE, 48, CBR_CR_DLY + 1, 8'h03);
		h.tick(40);
		chk(blk.size(), 1);
		chk_blk(0, t0, 16'hFFFF >> CBR_DAT_Z_CYCLES);
		chk(dat_oe, 1'h0);
		h.tick(8);
	endtask : single_read
	// Corrupted check bits draw no answer, data or report; an out-of-state acquisition is reported but draws no answer
	task automatic bad_read();
		int n, d, e;
		logic [7:0] wh;
		n = blk.size();
		e = n_evt;
		h.send(CBR_IDX_RD_ONE, 32'h0, 1'h1);
		h.recv(48, d, wh, resp);
		chk(d, 64);
		chk(blk.size(), n);
		chk(n_evt, e);
		h.tick(8);
		h.send(CBR_IDX_ALL_ID, 32'h0, 1'h0);
		h.recv(48, d, wh, resp);
		chk(d, 64);
		chk(n_evt, e + 1);
		h.tick(8 + 136);
	endtask : bad_read
	// Stop lands mid-block: the data line must still be let go two cycles later
	task automatic multi_read();
		int t0, n;
		n = blk.size();
		h.send(CBR_IDX_RD_MULTI, 32'h0, 1'h0);
		t0 = bc;
		rsp(CBR_IDX_RD_MULTI, 48, CBR_CR_DLY + 1, 8'h03);
		h.tick(140);
		h.send(CBR_IDX_STOP, 32'h0, 1'h0);
		chk({dat_oe, dat_out}, 2'h3);
		h.tick(1);
		chk(dat_oe, 1'h0);
		chk(blk.size() >= n + 3, 1'h1);
		chk_blk(n, t0, 16'hFFFF >> CBR_DAT_Z_CYCLES);
		for (int i = n + 1; i < n + 3; i++) begin
			chk_blk(i, 0, 16'hFFFF);
			chk(blk[i].d[31:24], blk[i - 1].d[7:0] + 8'h01);
		end
		h.tick(60);
	endtask : multi_read
	task automatic report_and_stop();
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		sys_rst = 1'h1;
		rd_valid = 1'h0;
		rd_data = 8'h00;
		od = 1'h0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'h0;
		rd_valid = 1'h1;
		#1.3; // Keeps the link edges off the system clock's edges
		ident_phase();
		select_setup();
		single_read();
		bad_read();
		multi_read();
		report_and_stop();
	end
	// Hang guard
	initial begin
		#300000;
		n_fail++;
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
